/* lfd_timer.sv */
// lfd package and per-channel lit/unlit interval timer
`timescale 1ns/10ps
`default_nettype none

package lfd_pkg;
    // -------------------------------------------------
    // channel count and timing
    // -------------------------------------------------
    localparam int LFD_NCH = 12;
    localparam int LFD_CLK_NS = 10;
    localparam int LFD_QUAL_NS = 5000;
    // least time, rounded up to whole cycles
    localparam int LFD_QUAL_CYC = (LFD_QUAL_NS + LFD_CLK_NS - 1) / LFD_CLK_NS;
    localparam int LFD_CNT_W = 10;
    localparam logic [LFD_CNT_W-1:0] LFD_QUAL_CNT = LFD_CNT_W'(LFD_QUAL_CYC);
    // -------------------------------------------------
    // register bus
    // -------------------------------------------------
    localparam int LFD_ADDR_W = 4;
    localparam logic [3:0] LFD_REG_CTRL = 4'h0;
    localparam logic [3:0] LFD_REG_OUT_EN = 4'h1;
    localparam logic [3:0] LFD_REG_OPEN_MASK = 4'h2;
    localparam logic [3:0] LFD_REG_OPEN_RES = 4'h3;
    localparam logic [3:0] LFD_REG_NS_RES = 4'h4;
    localparam logic [3:0] LFD_REG_STATUS1 = 4'h5;
    localparam logic [3:0] LFD_REG_RST_STAT = 4'h6;
    localparam logic [3:0] LFD_REG_IRQ_STAT = 4'h7;
    localparam logic [3:0] LFD_REG_IRQ_CLR = 4'h8;
    localparam logic [3:0] LFD_REG_IRQ_EN = 4'h9;
    // control register fields
    localparam int LFD_CTRL_OPEN_G = 0;
    localparam int LFD_CTRL_NS_G = 1;
    localparam int LFD_CTRL_SEL_LO = 2;
    localparam int LFD_CTRL_SEL_HI = 3;
    localparam logic [3:0] LFD_CTRL_RST = 4'h0;
    localparam logic [11:0] LFD_MASK_RST = 12'h000;
    // status flag 1 fields, also the interrupt layout for bits 2..0
    localparam int LFD_ST_OPEN = 0;
    localparam int LFD_ST_NS = 1;
    localparam int LFD_ST_SUP = 2;
    localparam int LFD_ST_OTHER = 3;
    localparam int LFD_NIRQ = 3;
    // -------------------------------------------------
    // synchronised input vector layout
    // -------------------------------------------------
    localparam int LFD_EXT_W = 5;
    localparam int LFD_SY_OPEN = 0;
    localparam int LFD_SY_NS = 12;
    localparam int LFD_SY_SUP1 = 24;
    localparam int LFD_SY_SUP2 = 25;
    localparam int LFD_SY_EXT = 26;
    localparam int LFD_SY_W = 31;
endpackage

module lfd_timer
    import lfd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // drive state of each output
    input wire logic [lfd_pkg::LFD_NCH-1:0] led_on,
    // state held longer than the qualifying interval
    output logic [lfd_pkg::LFD_NCH-1:0] lit_ok,
    output logic [lfd_pkg::LFD_NCH-1:0] dark_ok
);
    typedef struct packed {
        logic [LFD_NCH-1:0] prev;
        logic [LFD_NCH-1:0][LFD_CNT_W-1:0] cnt;
    } lfd_tmr_s;

    lfd_tmr_s st_q;
    lfd_tmr_s st_d;
    logic [LFD_NCH-1:0] long_q;

    // restart on every change of state, saturate just past the interval
    always_comb begin
        st_d = st_q;
        st_d.prev = led_on;
        for (int n = 0; n < LFD_NCH; n++) begin
            if (led_on[n] != st_q.prev[n]) begin
                st_d.cnt[n] = '0;
            end else if (st_q.cnt[n] <= LFD_QUAL_CNT) begin
                st_d.cnt[n] = st_q.cnt[n] + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // more than the interval, in the state still shown
    genvar g;
    generate
        for (g = 0; g < LFD_NCH; g++) begin : g_ch
            assign long_q[g] = (st_q.cnt[g] > LFD_QUAL_CNT) && (st_q.prev[g] == led_on[g]);
        end
    endgenerate
    assign lit_ok = long_q & led_on;
    assign dark_ok = long_q & ~led_on;
endmodule

`default_nettype wire

/* lfd_detect.sv */
// lfd fault supervision: open and neighbour-short results, supply flag, status, err pin
//
// Behaviour
// - open check runs only with output enabled, channel and global open masks set, lit over 5 us.
// - a qualified open check records 1 when the output sits below the open threshold, 0 otherwise.
// - the open fault flag goes to 1 once any channel records an open fault.
// - the open result bits and the open flag are returned on the matching reads.
// - results and the open, neighbour-short and supply flags hold once set and clear only by the reset-status command.
// - a cleared channel open mask stops that channel only; others stay checked.
// - neighbour-short checks ignore the output enable, need the global mask and both states over 5 us.
// - the neighbour-short comparison runs only while adjacent channels are in opposite states.
// - a qualified channel records 1 when the sense-to-output difference exceeds the short threshold.
// - the neighbour-short flag goes to 1 once any channel records a neighbour short.
// - the neighbour-short result bits and flag are returned on the matching reads.
// - neighbour-short checks have no per-channel disable, only the global mask.
// - supply select 1,0 uses the first threshold, 0,1 or 1,1 the second, 0,0 disables the check.
// - an enabled supply check flags 1 while sense sits below the selected threshold.
// - the supply flag is returned on the status flag read.
// - the abnormality pin is pulled low while any summary flag is set.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none

module lfd_detect
    import lfd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [lfd_pkg::LFD_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // drive state from the output stage
    input wire logic [lfd_pkg::LFD_NCH-1:0] led_on,
    // comparators, asynchronous
    input wire logic [lfd_pkg::LFD_NCH-1:0] open_cmp,
    input wire logic [lfd_pkg::LFD_NCH-1:0] ns_cmp,
    input wire logic supply_cmp_first,
    input wire logic supply_cmp_second,
    input wire logic [lfd_pkg::LFD_EXT_W-1:0] other_fault,
    // open-drain abnormality pin and interrupt
    output logic err_o,
    output logic err_oe,
    output logic irq
);
    // -------------------------------------------------
    // state
    // -------------------------------------------------
    typedef struct packed {
        logic [LFD_SY_W-1:0] sy1;
        logic [LFD_SY_W-1:0] sy2;
        logic [LFD_SY_W-1:0] sy3;
        logic [LFD_SY_W-1:0] filt;
        logic [3:0] ctrl;
        logic [LFD_NCH-1:0] output_enable_mask;
        logic [LFD_NCH-1:0] open_check_chan_mask;
        logic [LFD_NCH-1:0] open_result_bits;
        logic [LFD_NCH-1:0] neighbour_short_result_bits;
        logic open_fault_flag;
        logic neighbour_short_flag;
        logic supply_fault_flag;
        logic [LFD_NIRQ-1:0] irq_stat;
        logic [LFD_NIRQ-1:0] irq_en;
        logic [31:0] rdata;
        logic err_oe;
        logic irq;
    } lfd_state_s;

    lfd_state_s st_q;
    lfd_state_s st_d;
    logic [LFD_NCH-1:0] lit_ok;
    logic [LFD_NCH-1:0] dark_ok;
    logic [LFD_NCH-1:0] long_ok;
    logic [LFD_NCH-1:0] open_qual;
    logic [LFD_NCH-1:0] open_hit;
    logic [LFD_NCH-1:0] diff_dn;
    logic [LFD_NCH-1:0] diff_up;
    logic [LFD_NCH-1:0] ns_qual;
    logic [LFD_NCH-1:0] ns_hit;
    logic open_check_global_mask;
    logic neighbour_short_global_mask;
    logic supply_threshold_sel_lo;
    logic supply_threshold_sel_hi;
    logic sup_hit;
    logic other_any;
    logic rst_cmd;
    logic [LFD_NIRQ-1:0] ev;

    lfd_timer u_timer (
        .clk(clk),
        .rst(rst),
        .led_on(led_on),
        .lit_ok(lit_ok),
        .dark_ok(dark_ok)
    );

    // -------------------------------------------------
    // qualification
    // -------------------------------------------------
    assign open_check_global_mask = st_q.ctrl[LFD_CTRL_OPEN_G];
    assign neighbour_short_global_mask = st_q.ctrl[LFD_CTRL_NS_G];
    assign supply_threshold_sel_lo = st_q.ctrl[LFD_CTRL_SEL_LO];
    assign supply_threshold_sel_hi = st_q.ctrl[LFD_CTRL_SEL_HI];
    assign long_ok = lit_ok | dark_ok;

    // open: all three masks and a long enough lit time
    assign open_qual = st_q.output_enable_mask & st_q.open_check_chan_mask
        & {LFD_NCH{open_check_global_mask}} & lit_ok;
    assign open_hit = open_qual & st_q.filt[LFD_SY_OPEN +: LFD_NCH];

    // neighbour compare: bit n against n-1 and n+1, edges compare with themselves
    assign diff_dn = led_on ^ {led_on[LFD_NCH-2:0], led_on[0]};
    assign diff_up = led_on ^ {led_on[LFD_NCH-1], led_on[LFD_NCH-1:1]};
    // output enable is not part of this term on purpose
    assign ns_qual = {LFD_NCH{neighbour_short_global_mask}} & long_ok
        & ((diff_dn & {long_ok[LFD_NCH-2:0], 1'b0})
        | (diff_up & {1'b0, long_ok[LFD_NCH-1:1]}));
    assign ns_hit = ns_qual & st_q.filt[LFD_SY_NS +: LFD_NCH];

    // supply: hi selects the second threshold, lo alone the first
    assign sup_hit = supply_threshold_sel_hi ? st_q.filt[LFD_SY_SUP2]
        : (supply_threshold_sel_lo & st_q.filt[LFD_SY_SUP1]);

    assign other_any = |st_q.filt[LFD_SY_EXT +: LFD_EXT_W];
    assign rst_cmd = wr && (addr == LFD_REG_RST_STAT);
    assign ev = {sup_hit, |ns_hit, |open_hit};

    // -------------------------------------------------
    // next state
    // -------------------------------------------------
    // results are sticky; a hit in the reset-status cycle survives it
    always_comb begin
        st_d = st_q;
        // three-stage pin sync, taken once stages two and three agree
        st_d.sy1 = {other_fault, supply_cmp_second, supply_cmp_first, ns_cmp, open_cmp};
        st_d.sy2 = st_q.sy1;
        st_d.sy3 = st_q.sy2;
        st_d.filt = (~(st_q.sy2 ^ st_q.sy3) & st_q.sy3) | ((st_q.sy2 ^ st_q.sy3) & st_q.filt);
        if (rst_cmd) begin
            st_d.open_result_bits = '0;
            st_d.neighbour_short_result_bits = '0;
            st_d.open_fault_flag = 1'b0;
            st_d.neighbour_short_flag = 1'b0;
            st_d.supply_fault_flag = 1'b0;
        end
        st_d.open_result_bits = st_d.open_result_bits | open_hit;
        st_d.open_fault_flag = st_d.open_fault_flag | (|open_hit);
        st_d.neighbour_short_result_bits = st_d.neighbour_short_result_bits | ns_hit;
        st_d.neighbour_short_flag = st_d.neighbour_short_flag | (|ns_hit);
        st_d.supply_fault_flag = st_d.supply_fault_flag | sup_hit;
        // register writes
        if (wr) begin
            case (addr)
                LFD_REG_CTRL: st_d.ctrl = wdata[3:0];
                LFD_REG_OUT_EN: st_d.output_enable_mask = wdata[LFD_NCH-1:0];
                LFD_REG_OPEN_MASK: st_d.open_check_chan_mask = wdata[LFD_NCH-1:0];
                LFD_REG_IRQ_EN: st_d.irq_en = wdata[LFD_NIRQ-1:0];
                LFD_REG_IRQ_CLR: st_d.irq_stat = st_q.irq_stat & ~wdata[LFD_NIRQ-1:0];
                default: st_d.ctrl = st_q.ctrl;
            endcase
        end
        // events set after the clear so a same-cycle set wins
        st_d.irq_stat = st_d.irq_stat | ev;
        st_d.irq = |(st_d.irq_stat & st_d.irq_en);
        // pin low while any summary flag stands
        st_d.err_oe = st_d.open_fault_flag | st_d.neighbour_short_flag
            | st_d.supply_fault_flag | other_any;
        // read data stand in the cycle after the strobe only
        st_d.rdata = '0;
        if (rd) begin
            case (addr)
                LFD_REG_CTRL: st_d.rdata = {28'h0000000, st_q.ctrl};
                LFD_REG_OUT_EN: st_d.rdata = {20'h00000, st_q.output_enable_mask};
                LFD_REG_OPEN_MASK: st_d.rdata = {20'h00000, st_q.open_check_chan_mask};
                LFD_REG_OPEN_RES: st_d.rdata = {20'h00000, st_q.open_result_bits};
                LFD_REG_NS_RES: st_d.rdata = {20'h00000, st_q.neighbour_short_result_bits};
                LFD_REG_STATUS1: st_d.rdata = {28'h0000000, other_any, st_q.supply_fault_flag,
                    st_q.neighbour_short_flag, st_q.open_fault_flag};
                LFD_REG_IRQ_STAT: st_d.rdata = {29'h0, st_q.irq_stat};
                LFD_REG_IRQ_EN: st_d.rdata = {29'h0, st_q.irq_en};
                default: st_d.rdata = '0;
            endcase
        end
    end

    // -------------------------------------------------
    // registers
    // -------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.ctrl <= LFD_CTRL_RST;
            st_q.output_enable_mask <= LFD_MASK_RST;
            st_q.open_check_chan_mask <= LFD_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // pin only ever drives low; the enable carries the level
    assign err_o = 1'b0;
    assign err_oe = st_q.err_oe;
    assign irq = st_q.irq;
    assign rdata = st_q.rdata;

    // -------------------------------------------------
    // checks
    // -------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [LFD_NCH-1:0] open_hit_q;
    logic [LFD_NCH-1:0] ns_hit_q;
    logic [LFD_NCH-1:0] open_res_q;
    logic [LFD_NCH-1:0] ns_res_q;
    logic rd_open_q;
    logic rst_cmd_q;
    always_ff @(posedge clk) begin
        open_hit_q <= open_hit;
        ns_hit_q <= ns_hit;
        open_res_q <= st_q.open_result_bits;
        ns_res_q <= st_q.neighbour_short_result_bits;
        rd_open_q <= rd && (addr == LFD_REG_OPEN_RES);
        rst_cmd_q <= rst_cmd;
    end

    a_open_new_bits: assert property (!rst_cmd_q |-> ((st_q.open_result_bits & ~open_res_q & ~open_hit_q) == '0))
        else $error("open result set without a qualified hit");
    a_open_mask_gate: assert property (((~st_q.output_enable_mask | ~st_q.open_check_chan_mask) & open_hit) == '0)
        else $error("open hit on a masked channel");
    a_open_bit_set: assert property ((|open_hit) |=> ((st_q.open_result_bits & open_hit_q) == open_hit_q))
        else $error("open hit not recorded");
    a_open_flag_set: assert property ((|open_hit) |=> (st_q.open_fault_flag && st_q.err_oe))
        else $error("open flag or pin missed");
    a_result_hold: assert property (((open_res_q & ~st_q.open_result_bits) != '0) |-> rst_cmd_q)
        else $error("open result dropped without reset command");
    a_ns_opposite: assert property ((ns_hit & ~(diff_dn | diff_up)) == '0)
        else $error("neighbour check with equal states");
    a_ns_bit_set: assert property ((|ns_hit) |=> ((st_q.neighbour_short_result_bits & ns_hit_q) == ns_hit_q)
        && st_q.neighbour_short_flag)
        else $error("neighbour short not recorded");
    a_ns_new_bits: assert property (!rst_cmd_q |-> ((st_q.neighbour_short_result_bits & ~ns_res_q & ~ns_hit_q) == '0))
        else $error("neighbour result set without a hit");
    a_supply_off: assert property ((!supply_threshold_sel_lo && !supply_threshold_sel_hi
        && !st_q.supply_fault_flag) |=> !st_q.supply_fault_flag)
        else $error("supply flagged while disabled");
    a_err_pin: assert property ((st_q.open_fault_flag || st_q.neighbour_short_flag
        || st_q.supply_fault_flag) |-> st_q.err_oe)
        else $error("err pin released with a flag set");
    a_open_read: assert property (rd_open_q |-> (rdata[LFD_NCH-1:0] == open_res_q))
        else $error("open result read wrong");

    c_open_hit: cover property (|open_hit);
    c_ns_hit: cover property (|ns_hit);
    c_supply_hit: cover property (sup_hit ##1 irq);
    c_reset_status: cover property (st_q.open_fault_flag ##1 rst_cmd ##1 !st_q.open_fault_flag);
endmodule

`default_nettype wire

/* lfd_afe_model.sv */
// behavioural model of the analog front end feeding the fault comparators
`timescale 1ns/10ps
`default_nettype none

module lfd_afe_model
    import lfd_pkg::*;
(
    // drive state and injected faults
    input wire logic [lfd_pkg::LFD_NCH-1:0] led_on,
    input wire logic [lfd_pkg::LFD_NCH-1:0] open_fault,
    input wire logic [lfd_pkg::LFD_NCH-1:0] ns_fault,
    input wire logic [1:0] sup_low,
    // comparator outputs
    output logic [lfd_pkg::LFD_NCH-1:0] open_cmp,
    output logic [lfd_pkg::LFD_NCH-1:0] ns_cmp,
    output logic sup_first,
    output logic sup_second
);
    // an open output only sags below threshold while it is driven
    assign open_cmp = led_on & open_fault;
    // neighbour short shows on the difference amplifier whatever the state
    assign ns_cmp = ns_fault;
    // the two supply thresholds are judged independently
    assign sup_first = sup_low[0];
    assign sup_second = sup_low[1];
endmodule

`default_nettype wire

/* test_lfd_detect.sv */
// self-checking bench for the fault supervision block
`timescale 1ns/10ps
`default_nettype none

module test_lfd_detect;
    import lfd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [11:0] led_on = 12'h000;
    logic [11:0] open_f = 12'h000;
    logic [11:0] ns_f = 12'h000;
    logic [1:0] sup_f = 2'h0;
    logic [4:0] other_fault = 5'h00;
    logic [11:0] open_cmp;
    logic [11:0] ns_cmp;
    logic sup1;
    logic sup2;
    logic err_o;
    logic err_oe;
    logic irq;
    wire err_pin = err_oe ? err_o : 1'b1; // pull-up on the open-drain line
    int n_fail = 0;
    int total_checks = 0;
    int seed = 57719;
    logic [11:0] r_oe;
    logic [11:0] r_m;

    lfd_detect lfd_detect_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .led_on(led_on), .open_cmp(open_cmp), .ns_cmp(ns_cmp), .supply_cmp_first(sup1),
        .supply_cmp_second(sup2), .other_fault(other_fault), .err_o(err_o), .err_oe(err_oe), .irq(irq));
    lfd_afe_model lfd_afe_model_inst (.led_on(led_on), .open_fault(open_f), .ns_fault(ns_f),
        .sup_low(sup_f), .open_cmp(open_cmp), .ns_cmp(ns_cmp), .sup_first(sup1), .sup_second(sup2));

    // 100 MHz clock
    always #5 clk = ~clk;

    // ------------------------------
    // helpers
    // ------------------------------
    // selected threshold: hi bit picks the second, lo alone the first
    function automatic logic exp_sup(input logic [1:0] s, input logic [1:0] f);
        return s[1] ? f[1] : (s[0] ? f[0] : 1'b0);
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(nm, rdata, exp);
    endtask
    // step off the edge so registered outputs are settled when looked at
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // led dark while masks change, so the lit timer restarts cleanly
    task automatic run_open(input logic [11:0] oe, input logic [11:0] m, input logic [11:0] f);
        logic [11:0] e;
        e = oe & m & f;
        @(posedge clk);
        led_on <= 12'h000;
        open_f <= f;
        wr_reg(LFD_REG_OUT_EN, {20'h0, oe});
        wr_reg(LFD_REG_OPEN_MASK, {20'h0, m});
        wr_reg(LFD_REG_RST_STAT, 32'h1);
        @(posedge clk);
        led_on <= 12'hFFF;
        wait_cyc(LFD_QUAL_CYC - 60);
        rd_chk(LFD_REG_OPEN_RES, 32'h0, "open early");
        wait_cyc(80);
        rd_chk(LFD_REG_OPEN_RES, {20'h0, e}, "open result");
        rd_chk(LFD_REG_STATUS1, {31'h0, |e}, "open flag");
        check("err pin open", err_pin, !(|e));
    endtask

    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(LFD_REG_CTRL, 32'h0, "ctrl reset");
        rd_chk(LFD_REG_OPEN_MASK, 32'h0, "mask reset");
        rd_chk(LFD_REG_OUT_EN, 32'h0, "oe reset");
        rd_chk(LFD_REG_STATUS1, 32'h0, "status reset");
        wr_reg(4'hC, 32'hFFFF_FFFF);
        rd_chk(4'hC, 32'h0, "unmapped");
        wr_reg(LFD_REG_OPEN_RES, 32'hFFF);
        rd_chk(LFD_REG_OPEN_RES, 32'h0, "ro write");
        check("err pin reset", err_pin, 1'b1);
        end_test("reset");
        wr_reg(LFD_REG_CTRL, 32'h1);
        wr_reg(LFD_REG_IRQ_EN, 32'h7);
        run_open(12'hFFF, 12'hFFE, 12'h003);
        check("irq open", irq, 1'b1);
        @(posedge clk);
        open_f <= 12'h000;
        wait_cyc(10);
        rd_chk(LFD_REG_OPEN_RES, 32'h2, "open held");
        wr_reg(LFD_REG_RST_STAT, 32'h1);
        rd_chk(LFD_REG_OPEN_RES, 32'h0, "open cleared");
        for (int i = 0; i < 3; i++) begin
            r_oe = 12'($random(seed));
            r_m = 12'($random(seed));
            run_open(r_oe, r_m, 12'hFFF);
        end
        end_test("open");
        @(posedge clk);
        open_f <= 12'h000;
        ns_f <= 12'h028;
        led_on <= 12'h555;
        wr_reg(LFD_REG_CTRL, 32'h0);
        wr_reg(LFD_REG_OUT_EN, 32'h0);
        wait_cyc(6);
        wr_reg(LFD_REG_RST_STAT, 32'h1);
        wait_cyc(600);
        rd_chk(LFD_REG_NS_RES, 32'h0, "ns masked");
        @(posedge clk);
        led_on <= 12'hFFF;
        wr_reg(LFD_REG_CTRL, 32'h2);
        wait_cyc(600);
        rd_chk(LFD_REG_NS_RES, 32'h0, "ns same state");
        @(posedge clk);
        led_on <= 12'h555;
        wait_cyc(LFD_QUAL_CYC - 60);
        rd_chk(LFD_REG_NS_RES, 32'h0, "ns early");
        wait_cyc(80);
        rd_chk(LFD_REG_NS_RES, 32'h028, "ns result");
        rd_chk(LFD_REG_STATUS1, 32'h2, "ns flag");
        end_test("neighbour");
        @(posedge clk);
        ns_f <= 12'h000;
        wait_cyc(6);
        for (int s = 0; s < 4; s++) begin
            for (int f = 1; f < 3; f++) begin
                wr_reg(LFD_REG_RST_STAT, 32'h1);
                wr_reg(LFD_REG_CTRL, {28'h0, 2'(s), 2'b00});
                @(posedge clk);
                sup_f <= 2'(f);
                wait_cyc(8);
                rd_chk(LFD_REG_STATUS1, {29'h0, exp_sup(2'(s), 2'(f)), 2'b00}, "supply");
                @(posedge clk);
                sup_f <= 2'h0;
                wait_cyc(6);
            end
        end
        end_test("supply");
        wr_reg(LFD_REG_IRQ_CLR, 32'h7);
        wr_reg(LFD_REG_IRQ_EN, 32'h4);
        wr_reg(LFD_REG_CTRL, 32'h4);
        rd_chk(LFD_REG_IRQ_EN, 32'h4, "irq enable");
        rd_chk(LFD_REG_IRQ_STAT, 32'h0, "irq cleared");
        @(posedge clk);
        sup_f <= 2'h1;
        wait_cyc(8);
        check("irq raised", irq, 1'b1);
        rd_chk(LFD_REG_IRQ_STAT, 32'h4, "irq stat");
        wr_reg(LFD_REG_IRQ_EN, 32'h0);
        @(posedge clk);
        #1;
        check("irq masked", irq, 1'b0);
        @(posedge clk);
        sup_f <= 2'h0;
        wait_cyc(6);
        wr_reg(LFD_REG_IRQ_CLR, 32'h4);
        wr_reg(LFD_REG_IRQ_EN, 32'h4);
        wait_cyc(2);
        check("irq after clear", irq, 1'b0);
        @(posedge clk);
        other_fault <= 5'h10;
        wait_cyc(6);
        rd_chk(LFD_REG_STATUS1, 32'hC, "other fault");
        check("err pin other", err_pin, 1'b0);
        @(posedge clk);
        other_fault <= 5'h00;
        wait_cyc(6);
        wr_reg(LFD_REG_RST_STAT, 32'h1);
        wait_cyc(3);
        check("err pin idle", err_pin, 1'b1);
        end_test("irq and pin");
        complete_run;
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule

`default_nettype wire
